// ### mbc_bus_ctrl.sv
// bus sequencer for memory, serial io and bus hold
// assumes the core issues one request at a time and waits on done_out
`default_nettype none

module mbc_bus_ctrl (
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_in,
    input  wire mbc_pkg::mbc_req_t             req_in,
    input  wire logic                          hold_req_n_in,
    input  wire logic                          ready_in,
    input  wire logic                          serial_io_input_in,
    input  wire logic [mbc_pkg::DATA_W-1:0]    data_in,
    output var  mbc_pkg::mbc_pins_t            pins_out,
    output var  logic                          done_out,
    output var  logic [mbc_pkg::DATA_W-1:0]    rdata_out,
    output var  logic                          sbit_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mbc_pkg::mbc_state_t           st;       // sequencer state
        mbc_pkg::mbc_op_t              op;       // kind of cycle in flight
        mbc_pkg::mbc_pins_t            pins;     // registered pin drive
        logic                          done;     // one-cycle completion
        logic [mbc_pkg::DATA_W-1:0]    rdata;    // captured read data
        logic                          sbit;     // captured serial input
        logic [1:0]                    ser_cnt;  // serial input settle count
        logic                          last_mem; // previous cycle was memory
        logic [1:0]                    hold_s;   // hold request synchroniser
        logic [1:0]                    rdy_s;    // ready synchroniser
        logic [1:0]                    sin_s;    // serial input synchroniser
        logic [mbc_pkg::DATA_W-1:0]    din_s1;   // data first stage
        logic [mbc_pkg::DATA_W-1:0]    din_s2;   // data second stage
    } mbc_ctl_t;

    mbc_ctl_t s_q;   // registered state
    mbc_ctl_t s_d;   // next state

    logic hold_want;   // synchronised hold request, active high
    logic rdy;         // synchronised ready
    logic is_mem;      // incoming request is a memory cycle

    assign hold_want = ~s_q.hold_s[1];
    assign rdy       = s_q.rdy_s[1];
    assign is_mem    = req_in.valid && (req_in.op == mbc_pkg::MBC_OP_READ ||
                       req_in.op == mbc_pkg::MBC_OP_FETCH ||
                       req_in.op == mbc_pkg::MBC_OP_WRITE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        // pin inputs pass two flops; first stage read only by second
        s_d.hold_s = {s_q.hold_s[0], hold_req_n_in};
        s_d.rdy_s  = {s_q.rdy_s[0], ready_in};
        s_d.sin_s  = {s_q.sin_s[0], serial_io_input_in};
        s_d.din_s1 = data_in;
        s_d.din_s2 = s_q.din_s1;
        unique case (s_q.st)
            mbc_pkg::MBC_ST_IDLE: begin
                s_d.pins.sclk     = 1'b0;
                s_d.pins.mem_n    = 1'b1;
                s_d.pins.we_n     = 1'b1;
                s_d.pins.rd_dir   = 1'b0;
                s_d.pins.fetch    = 1'b0;
                s_d.pins.data_oe  = 1'b0;
                // hold waits only if the prior cycle was memory and this request is memory too
                if (hold_want && !(s_q.last_mem && is_mem)) begin
                    s_d.st           = mbc_pkg::MBC_ST_HOLD;
                    s_d.pins.addr_oe = 1'b0;
                    s_d.pins.ctl_oe  = 1'b0;
                    s_d.last_mem     = 1'b0;
                end else if (req_in.valid) begin
                    s_d.op        = req_in.op;
                    s_d.pins.addr = req_in.addr;
                    // a cycle chained past a pending hold is the last one before it
                    s_d.last_mem  = is_mem && !hold_want;
                    if (is_mem) begin
                        s_d.st         = mbc_pkg::MBC_ST_MEM;
                        // stale ready from the last cycle must not end this one
                        s_d.rdy_s      = 2'h0;
                        s_d.pins.mem_n = 1'b0;
                        s_d.pins.fetch = (req_in.op == mbc_pkg::MBC_OP_FETCH);
                        if (req_in.op == mbc_pkg::MBC_OP_WRITE) begin
                            s_d.pins.data    = req_in.wdata;
                            s_d.pins.data_oe = 1'b1;
                            s_d.pins.we_n    = 1'b0;
                        end else begin
                            s_d.pins.rd_dir  = 1'b1;
                        end
                    end else if (req_in.op == mbc_pkg::MBC_OP_NONE) begin
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st        = mbc_pkg::MBC_ST_SER;
                        s_d.ser_cnt   = 2'h0;
                        s_d.pins.sclk = (req_in.op != mbc_pkg::MBC_OP_SIN);
                        if (req_in.op == mbc_pkg::MBC_OP_SOUT) begin
                            s_d.pins.addr[mbc_pkg::SER_LN] = req_in.sbit;
                        end
                    end
                end else begin
                    s_d.last_mem = 1'b0;
                end
            end
            mbc_pkg::MBC_ST_MEM: begin
                // wait states until ready seen high
                if (rdy) begin
                    s_d.st        = mbc_pkg::MBC_ST_IDLE;
                    s_d.done      = 1'b1;
                    s_d.rdata     = s_q.din_s2;
                    s_d.pins.we_n = 1'b1;
                end
            end
            mbc_pkg::MBC_ST_SER: begin
                // output slot is one cycle; input waits for the synchroniser
                // to carry the level selected by the new bit address
                s_d.pins.sclk = 1'b0;
                s_d.ser_cnt   = s_q.ser_cnt + 2'h1;
                if (s_q.op != mbc_pkg::MBC_OP_SIN || s_q.ser_cnt == 2'h2) begin
                    s_d.st   = mbc_pkg::MBC_ST_IDLE;
                    s_d.done = 1'b1;
                end
                if (s_q.op == mbc_pkg::MBC_OP_SIN && s_q.ser_cnt == 2'h2) begin
                    s_d.sbit = s_q.sin_s[1];
                end
            end
            mbc_pkg::MBC_ST_HOLD: begin
                s_d.pins.grant = 1'b1;
                if (!hold_want) begin
                    s_d.st         = mbc_pkg::MBC_ST_REL;
                    s_d.pins.grant = 1'b0;
                end
            end
            mbc_pkg::MBC_ST_REL: begin
                // re-drive outputs idle for a cycle before any request
                s_d.st           = mbc_pkg::MBC_ST_IDLE;
                s_d.pins.addr_oe = 1'b1;
                s_d.pins.ctl_oe  = 1'b1;
            end
            default: begin
                s_d.st = mbc_pkg::MBC_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q              <= '0;
            s_q.hold_s       <= 2'h3;
            s_q.pins.mem_n   <= 1'b1;
            s_q.pins.we_n    <= 1'b1;
            s_q.pins.addr_oe <= 1'b1;
            s_q.pins.ctl_oe  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_out  = s_q.pins;
    assign done_out  = s_q.done;
    assign rdata_out = s_q.rdata;
    assign sbit_out  = s_q.sbit;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence grant_rise;
        !s_q.pins.grant ##1 s_q.pins.grant;
    endsequence

    // the qualifier stands through the done cycle, address still on the bus
    a_mem_only_mem: assert property (!s_q.pins.mem_n |->
        s_q.st == mbc_pkg::MBC_ST_MEM || s_q.done)
        else $error("memory qualifier low outside a memory cycle");
    a_we_with_data: assert property (!s_q.pins.we_n |-> s_q.pins.data_oe && !s_q.pins.rd_dir)
        else $error("write strobe without driven data");
    a_sclk_one_cycle: assert property (s_q.pins.sclk |=> !s_q.pins.sclk)
        else $error("shift clock high too long");
    a_grant_floated: assert property (grant_rise |-> !s_q.pins.addr_oe && !s_q.pins.ctl_oe)
        else $error("grant given with bus still driven");
    a_hold_after_mem: assert property (s_q.st == mbc_pkg::MBC_ST_MEM |=> s_q.st != mbc_pkg::MBC_ST_HOLD)
        else $error("hold entered mid memory cycle");
    a_wait_on_ready: assert property (s_q.st == mbc_pkg::MBC_ST_MEM && !rdy |=> s_q.st == mbc_pkg::MBC_ST_MEM && !s_q.done)
        else $error("memory cycle ended without ready");
    a_release_redrive: assert property ($fell(s_q.pins.grant) |=> s_q.pins.addr_oe && s_q.pins.ctl_oe && s_q.st == mbc_pkg::MBC_ST_IDLE)
        else $error("bus not re-driven after hold");
    a_hold_leave: assert property (s_q.st == mbc_pkg::MBC_ST_HOLD && !hold_want |=> s_q.st == mbc_pkg::MBC_ST_REL)
        else $error("hold not left on release");
    a_fetch_in_mem: assert property (s_q.pins.fetch |-> !s_q.pins.mem_n && s_q.op == mbc_pkg::MBC_OP_FETCH)
        else $error("fetch indicator outside fetch cycle");
    a_rd_dir_read: assert property (s_q.pins.rd_dir |-> !s_q.pins.mem_n && s_q.pins.we_n)
        else $error("read direction outside a read");
    a_sin_sampled: assert property (s_q.st == mbc_pkg::MBC_ST_SER &&
        s_q.op == mbc_pkg::MBC_OP_SIN && s_q.ser_cnt == 2'h2 |=>
        sbit_out == $past(s_q.sin_s[1]))
        else $error("serial input not sampled");
    // a chained memory cycle is taken once, then hold must win
    a_chain_bounded: assert property (s_q.st == mbc_pkg::MBC_ST_IDLE && hold_want &&
        s_q.last_mem && is_mem |=> s_q.st == mbc_pkg::MBC_ST_MEM && !s_q.last_mem)
        else $error("chained memory cycle not bounded before hold");

endmodule

`default_nettype wire

// ### mbc_pkg.sv
// package for the memory and serial io bus control block
// assumes a single 40 MHz clock and a synchronous active-high reset
`default_nettype none

package mbc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 14;    // address bus, bit 0 is line a13
    localparam int unsigned DATA_W = 8;     // data bus
    localparam int unsigned SER_LN = 0;     // lsb index that carries line a13

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam int unsigned SHIFT_CLK_CYC = 1;   // shift clock high time in cycles

    // cycle kinds asked for by the core
    typedef enum logic [2:0] {
        MBC_OP_NONE  = 3'h0,   // internal cycle
        MBC_OP_READ  = 3'h1,   // memory read
        MBC_OP_FETCH = 3'h2,   // instruction fetch read
        MBC_OP_WRITE = 3'h3,   // memory write
        MBC_OP_SOUT  = 3'h4,   // serial bit out
        MBC_OP_SIN   = 3'h5,   // serial bit in
        MBC_OP_EXT   = 3'h6    // external instruction code
    } mbc_op_t;

    // bus sequencer states
    typedef enum logic [2:0] {
        MBC_ST_IDLE = 3'h0,    // no cycle
        MBC_ST_MEM  = 3'h1,    // memory cycle, waits on ready
        MBC_ST_SER  = 3'h2,    // serial cycle, shift clock high unless serial in
        MBC_ST_HOLD = 3'h3,    // bus floated, grant given
        MBC_ST_REL  = 3'h4     // re-driving after hold
    } mbc_state_t;

    // request from the core
    typedef struct packed {
        logic                valid;   // cycle wanted
        mbc_op_t             op;      // cycle kind
        logic [ADDR_W-1:0]   addr;    // address or serial bit address
        logic [DATA_W-1:0]   wdata;   // write data
        logic                sbit;    // serial output bit
    } mbc_req_t;

    // pin side drive
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;    // address lines
        logic                addr_oe; // address lines driven
        logic [DATA_W-1:0]   data;    // data lines
        logic                data_oe; // data lines driven
        logic                mem_n;   // memory qualifier, low active
        logic                we_n;    // write strobe, low active
        logic                ctl_oe;  // control outputs driven
        logic                rd_dir;  // read direction
        logic                fetch;   // instruction fetch indicator
        logic                sclk;    // serial shift clock
        logic                grant;   // bus grant acknowledge
    } mbc_pins_t;

endpackage

`default_nettype wire

// ### mbc_mem_model.sv
// partner model: memory, serial io logic on the pin side of the sequencer
// assumes pins come straight from the sequencer, one 40 MHz clock
`default_nettype none
module mbc_mem_model (
    input  wire logic                       ref_clk_in,
    input  wire mbc_pkg::mbc_pins_t         pins_in,
    input  wire logic [3:0]                 wait_in,
    output var  logic                       ready_out,
    output var  logic [mbc_pkg::DATA_W-1:0] data_out,
    output var  logic                       sin_out,
    output var  logic                       sout_out
);
    logic [7:0] mem_q [16];  // storage, arbitrary fill
    logic [3:0] cnt_q;       // cycles of the current memory access
    logic [7:0] last_q;      // last value put on the data lines
    // ------------------------------------------------------------
    // memory side
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) mem_q[i] = 8'h5A ^ 8'(i);
        cnt_q = 4'h0;
        last_q = 8'h00;
        sout_out = 1'b0;
    end
    // ready only after the chosen delay, never outside a cycle
    always_comb ready_out = !pins_in.mem_n && pins_in.ctl_oe && cnt_q >= wait_in;
    // read data while read direction is up, else a changing pattern
    always_comb data_out = (pins_in.rd_dir && pins_in.ctl_oe && !pins_in.mem_n)
        ? mem_q[pins_in.addr[3:0]] : ~last_q;
    // input bit is a function of the bit address on a2..a12
    always_comb sin_out = ^pins_in.addr[11:1];
    // plain always: the initial block above seeds these same variables
    always @(posedge ref_clk_in) begin
        last_q <= data_out;
        cnt_q <= (!pins_in.mem_n && pins_in.ctl_oe && cnt_q != 4'hF) ? cnt_q + 4'h1 : 4'h0;
        if (!pins_in.we_n && pins_in.ctl_oe && pins_in.data_oe) begin
            mem_q[pins_in.addr[3:0]] <= pins_in.data;
        end
        if (pins_in.sclk) begin
            sout_out <= pins_in.addr[0];
        end
    end
endmodule
`default_nettype wire

// ### mbc_bus_ctrl_tb.sv
// testbench for the bus sequencer: random memory and serial traffic, then a directed hold
// assumes the partner model answers on the pin side
`default_nettype none
module mbc_bus_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                ref_clk_in, rst_in, hold_n, rdy, sin, sout, done, sbit, mem;
    mbc_pkg::mbc_req_t   req;         // core request
    mbc_pkg::mbc_pins_t  pins;        // pin side drive
    mbc_pkg::mbc_op_t    op;          // cycle kind under test
    logic [7:0]          dat, rdata, d;
    logic [13:0]         a;
    logic [3:0]          wt;          // ready delay of the model
    logic [7:0]          shadow [16]; // expected memory contents
    logic [5:0]          seen;        // grant,sclk,rd,fetch,we,mem seen
    int                  err_total, num_checks, seed, cyc;
    mbc_bus_ctrl uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req),
        .hold_req_n_in(hold_n), .ready_in(rdy), .serial_io_input_in(sin),
        .data_in(dat), .pins_out(pins), .done_out(done), .rdata_out(rdata), .sbit_out(sbit));
    mbc_mem_model model (.ref_clk_in(ref_clk_in), .pins_in(pins), .wait_in(wt),
        .ready_out(rdy), .data_out(dat), .sin_out(sin), .sout_out(sout));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one request, held until done, pins watched every cycle
    task automatic do_op(input mbc_pkg::mbc_op_t o, input logic [13:0] ad, input logic [7:0] wd);
        @(negedge ref_clk_in);
        req = '{valid: 1'b1, op: o, addr: ad, wdata: wd, sbit: wd[0]};
        seen = '0;
        cyc = 0;
        while (done !== 1'b1) begin
            @(posedge ref_clk_in);
            #1;
            cyc++;
            seen |= {pins.grant && !pins.mem_n, pins.sclk, pins.rd_dir, pins.fetch,
                     !pins.we_n, !pins.mem_n};
            if (cyc > 300) begin
                err_total++;
                finish_test();
            end
        end
        @(negedge ref_clk_in);
        req.valid = 1'b0;
    endtask
    task automatic wait_grant(input logic v);
        for (int i = 0; pins.grant !== v; i++) begin
            @(posedge ref_clk_in);
            #1;
            if (i > 50) begin
                err_total++;
                finish_test();
            end
        end
    endtask
    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        seed = 32'hd29b;
        err_total = 0;
        num_checks = 0;
        rst_in = 1'b1;
        hold_n = 1'b1;
        req = '0;
        wt = 4'h0;
        for (int i = 0; i < 16; i++) shadow[i] = 8'h5A ^ 8'(i);
        repeat (6) @(negedge ref_clk_in);
        rst_in = 1'b0;
        chk({pins.mem_n, pins.we_n, pins.grant, pins.sclk, done}, 5'b11000);
        // random traffic over every cycle kind
        for (int n = 0; n < 49; n++) begin
            op = mbc_pkg::mbc_op_t'(3'(n % 7));
            a = 14'($random(seed));
            d = 8'($random(seed));
            wt = 4'($unsigned($random(seed)) % 6);
            do_op(op, a, d);
            mem = op inside {mbc_pkg::MBC_OP_READ, mbc_pkg::MBC_OP_FETCH, mbc_pkg::MBC_OP_WRITE};
            chk(seen[0], mem);
            chk(seen[1], op == mbc_pkg::MBC_OP_WRITE);
            chk(seen[2], op == mbc_pkg::MBC_OP_FETCH);
            chk(seen[3], mem && op != mbc_pkg::MBC_OP_WRITE);
            chk(seen[4], op inside {mbc_pkg::MBC_OP_SOUT, mbc_pkg::MBC_OP_EXT});
            // model delay plus two synchroniser stages plus launch and done edges
            if (mem) chk(16'(cyc), 16'(wt) + 16'h4);
            if (op == mbc_pkg::MBC_OP_WRITE) shadow[a[3:0]] = d;
            if (seen[3]) chk(rdata, shadow[a[3:0]]);
            if (op == mbc_pkg::MBC_OP_SOUT) chk(sout, d[0]);
            if (op == mbc_pkg::MBC_OP_SIN) chk(sbit, ^a[11:1]);
        end
        // hold requested while a slow read is under way
        wt = 4'h5;
        fork
            do_op(mbc_pkg::MBC_OP_READ, 14'h0006, 8'h00);
            begin
                repeat (2) @(negedge ref_clk_in);
                hold_n = 1'b0;
            end
        join
        chk(rdata, shadow[6]);
        chk(seen[5], 1'b0);
        wait_grant(1'b1);
        chk({pins.addr_oe, pins.data_oe, pins.ctl_oe}, 3'b000);
        @(negedge ref_clk_in);
        hold_n = 1'b1;
        wait_grant(1'b0);
        @(posedge ref_clk_in);
        #1;
        chk({pins.addr_oe, pins.ctl_oe}, 2'b11);
        do_op(mbc_pkg::MBC_OP_FETCH, 14'h000A, 8'h00);
        chk(rdata, shadow[10]);
        chk(seen[2], 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
